// >>> design/aipv_pkg.sv
// constants, field layout and helper functions for the audio input port
// Behaviour
// - mode bit: 0 stereo, 1 TDM; resets 1
// - format 0 delays first bit one clock
// - clock polarity picks rising or falling sample
// - stereo: sync bit picks left level
// - TDM: sync bit ignored, pulsed and 50% sync both open on the rising edge
// - slot width code selects 16..64 bit clocks
// - stereo or single TDM: any clocks per frame
// - polarity bit inverts the audio sign
// - rate field selects sample rate range
// - high-pass filter bit, on after reset
// - low power bit, on after reset
// - volume 0.375 dB steps, 0x40 is unity
// - code ff mutes, fe is -71.25 dB
// - width bit: 24 or 16 bit words
// - slot from field or address pin
package aipv_pkg;
  // -------------------------------------------------------------
  // register offsets and reset values
  // -------------------------------------------------------------
  localparam logic [7:0] ADDR_CONV = 8'h02; // converter_config
  localparam logic [7:0] ADDR_VOL = 8'h03; // digital_volume
  localparam logic [7:0] ADDR_SAI = 8'h04; // serial_port_config
  localparam logic [7:0] RST_CONV = 8'h32;
  localparam logic [7:0] RST_VOL = 8'h40;
  localparam logic [7:0] RST_SAI = 8'h11;
  // -------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------
  localparam int CONV_IMM_BIT = 7; // immediate_volume_sel
  localparam int CONV_MUTE_BIT = 6;
  localparam int CONV_HPF_BIT = 5; // highpass_enable
  localparam int CONV_LPM_BIT = 4; // low_power_enable
  localparam int CONV_RATE_LSB = 0; // sample_rate_range, 3 bits
  localparam int SAI_INV_BIT = 7; // output_invert
  localparam int SAI_EDGE_BIT = 6; // sample_edge_sel
  localparam int SAI_SLOTW_LSB = 3; // slot_width_sel, 3 bits
  localparam int SAI_STYLE_BIT = 2; // sync_style_sel
  localparam int SAI_DELAY_BIT = 1; // data_delay_sel
  localparam int FRAMING_MODE_SEL_BIT = 0; // framing_mode_sel
  // -------------------------------------------------------------
  // datapath constants
  // -------------------------------------------------------------
  localparam logic [7:0] VOL_MUTE_CODE = 8'hff;
  localparam logic [4:0] WORD_WIDE = 5'h18; // 24 bit words
  localparam logic [4:0] WORD_NARROW = 5'h10; // 16 bit words
  localparam logic [10:0] CNT_MAX = 11'h7ff; // bit counter saturation
  localparam int HPF_SHIFT = 10; // dc-blocker pole
  localparam logic [4:0] GAIN_SHIFT_BASE = 5'h0b; // +24 dB at code 0

  // bit clocks per chip from slot_width_sel
  function automatic logic [6:0] slot_bits(input logic [2:0] sel);
    case (sel)
      3'h0: slot_bits = 7'h10;
      3'h1: slot_bits = 7'h18;
      3'h2: slot_bits = 7'h20;
      3'h3: slot_bits = 7'h30;
      3'h4: slot_bits = 7'h40;
      default: slot_bits = 7'h20; // unassigned codes act as 32
    endcase
  endfunction : slot_bits

  // 0.375 dB fractional steps within one 6 dB octave, Q1.15
  function automatic logic [15:0] vol_mant(input logic [3:0] m);
    case (m)
      4'h0: vol_mant = 16'h8000;
      4'h1: vol_mant = 16'h7a98;
      4'h2: vol_mant = 16'h756b;
      4'h3: vol_mant = 16'h7075;
      4'h4: vol_mant = 16'h6bb5;
      4'h5: vol_mant = 16'h6728;
      4'h6: vol_mant = 16'h62cd;
      4'h7: vol_mant = 16'h5ea1;
      4'h8: vol_mant = 16'h5a9e;
      4'h9: vol_mant = 16'h56ca;
      4'ha: vol_mant = 16'h5320;
      4'hb: vol_mant = 16'h4f9d;
      4'hc: vol_mant = 16'h4c40;
      4'hd: vol_mant = 16'h4908;
      4'he: vol_mant = 16'h45f2;
      default: vol_mant = 16'h42fe;
    endcase
  endfunction : vol_mant

  // clamp a wide signed value to 24 bits
  function automatic logic signed [23:0] sat24(input logic signed [41:0] v);
    if (v > 42'sh7fffff) sat24 = 24'sh7fffff;
    else if (v < -42'sh800000) sat24 = -24'sh800000;
    else sat24 = v[23:0];
  endfunction : sat24
endpackage : aipv_pkg

// >>> design/aipv_link_if.sv
// carrier between the bit-clock receiver and the system-clock core
`timescale 1ns/1ns
interface aipv_link_if;
  logic [23:0] word; // last received word, left aligned
  logic tgl; // flips once per received word
  logic [7:0] sai_cfg; // serial_port_config image
  logic word16; // 16 bit words when high
  logic auto_slot; // slot from address pin
  logic [3:0] slot_field; // programmed slot
  logic [1:0] addr_slot; // address pin slot
  modport rx (output word, output tgl, input sai_cfg, input word16,
    input auto_slot, input slot_field, input addr_slot);
  modport core (input word, input tgl, output sai_cfg, output word16,
    output auto_slot, output slot_field, output addr_slot);
endinterface : aipv_link_if

// >>> design/aipv_rx.sv
// serial audio receiver running on the host's bit clock
`timescale 1ns/1ns
module aipv_rx
  import aipv_pkg::*;
(
  input wire logic bclk,
  input wire logic rst,
  input wire logic frame_sync_pin,
  input wire logic serial_data_pin,
  aipv_link_if.rx link
);
  // -------------------------------------------------------------
  // falling-edge capture of the pins
  // -------------------------------------------------------------
  logic neg_fs_q, neg_sd_q;
  always_ff @(negedge bclk or posedge rst) begin
    if (rst) begin
      neg_fs_q <= 1'b0;
      neg_sd_q <= 1'b0;
    end else begin
      neg_fs_q <= frame_sync_pin;
      neg_sd_q <= serial_data_pin;
    end
  end
  // -------------------------------------------------------------
  // config crossing, two flops in this domain
  // -------------------------------------------------------------
  // layout: addr slot 15:14, slot field 13:10, auto 9, width 8, port 7:0
  logic [15:0] cfg_s1_q, cfg_s2_q;
  always_ff @(posedge bclk or posedge rst) begin
    if (rst) begin
      cfg_s1_q <= {8'h00, RST_SAI};
      cfg_s2_q <= {8'h00, RST_SAI};
    end else begin
      cfg_s1_q <= {link.addr_slot, link.slot_field, link.auto_slot, link.word16, link.sai_cfg};
      cfg_s2_q <= cfg_s1_q;
    end
  end
  // -------------------------------------------------------------
  // framing and shift
  // -------------------------------------------------------------
  logic fs, sd, tdm, delay1, style, start, leave, armed_q, armed_d, emit;
  logic fs_prev_q, tgl_q, tgl_d;
  logic [10:0] cnt_q, cnt_d, base, rel;
  logic [3:0] slotnum;
  logic [4:0] wbits;
  logic [23:0] sh_q, sh_d, word_q, word_d;
  always_comb begin
    tdm = cfg_s2_q[FRAMING_MODE_SEL_BIT];
    delay1 = !cfg_s2_q[SAI_DELAY_BIT];
    style = cfg_s2_q[SAI_STYLE_BIT];
    fs = cfg_s2_q[SAI_EDGE_BIT] ? neg_fs_q : frame_sync_pin;
    sd = cfg_s2_q[SAI_EDGE_BIT] ? neg_sd_q : serial_data_pin;
    wbits = cfg_s2_q[8] ? WORD_NARROW : WORD_WIDE;
    slotnum = cfg_s2_q[9] ? {2'b00, cfg_s2_q[15:14]} : cfg_s2_q[13:10];
    // pulsed and 50% sync both open the frame on the rising edge
    if (tdm) start = fs && !fs_prev_q;
    else start = (fs == style) && (fs_prev_q != style);
    leave = !tdm && (fs != style) && (fs_prev_q == style);
    cnt_d = start ? 11'h000 : ((cnt_q == CNT_MAX) ? cnt_q : cnt_q + 11'h001);
    base = 11'(delay1) + (tdm ? 11'(slotnum) * 11'(slot_bits(cfg_s2_q[5:3])) : 11'h000);
    rel = cnt_d - base;
    armed_d = armed_q || start;
    sh_d = start ? 24'h000000 : sh_q;
    word_d = word_q;
    tgl_d = tgl_q;
    emit = 1'b0;
    if (armed_d && !leave && cnt_d >= base && rel < 11'(wbits)) begin
      sh_d[5'(5'h17 - rel[4:0])] = sd;
      emit = (rel == 11'(wbits) - 11'h001);
    end else if (armed_d && leave && cnt_d > base) begin
      emit = 1'b1; // short channel, keep what arrived
    end
    if (emit) begin
      armed_d = 1'b0;
      word_d = sh_d;
      tgl_d = !tgl_q;
    end
  end
  always_ff @(posedge bclk or posedge rst) begin
    if (rst) begin
      fs_prev_q <= 1'b0;
      cnt_q <= CNT_MAX;
      armed_q <= 1'b0;
      sh_q <= 24'h000000;
      word_q <= 24'h000000;
      tgl_q <= 1'b0;
    end else begin
      fs_prev_q <= fs;
      cnt_q <= cnt_d;
      armed_q <= armed_d;
      sh_q <= sh_d;
      word_q <= word_d;
      tgl_q <= tgl_d;
    end
  end
  assign link.word = word_q;
  assign link.tgl = tgl_q;

  property p_rx_narrow;
    @(posedge bclk) disable iff (rst) emit && cfg_s2_q[8] |=> word_q[7:0] == 8'h00;
  endproperty
  a_rx_narrow: assert property (p_rx_narrow) else $error("narrow word has low bits");
  property p_rx_start;
    @(posedge bclk) disable iff (rst) start |=> cnt_q == 11'h000 && armed_q;
  endproperty
  a_rx_start: assert property (p_rx_start) else $error("frame start not taken");
  property p_rx_nodelay;
    @(posedge bclk) disable iff (rst) start && !delay1 && !tdm |=> sh_q[23] == $past(sd);
  endproperty
  a_rx_nodelay: assert property (p_rx_nodelay) else $error("first bit not taken at edge");
endmodule : aipv_rx

// >>> design/aipv_top.sv
// audio input port core: registers, crossing, filter, volume, buffer
`timescale 1ns/1ns
module aipv_top
  import aipv_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic bclk,
  input wire logic frame_sync_pin,
  input wire logic serial_data_pin,
  input wire logic [1:0] addr_slot_pin,
  input wire logic word16_sel,
  input wire logic auto_slot_sel,
  input wire logic [3:0] slot_field,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [23:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic low_power_enable,
  output logic [2:0] sample_rate_range
);
  // -------------------------------------------------------------
  // receiver in the bit-clock domain
  // -------------------------------------------------------------
  aipv_link_if link ();

  aipv_rx u_rx (
    .bclk(bclk),
    .rst(rst),
    .frame_sync_pin(frame_sync_pin),
    .serial_data_pin(serial_data_pin),
    .link(link)
  );

  // -------------------------------------------------------------
  // register file
  // -------------------------------------------------------------
  logic [7:0] conv_q, conv_d; // converter_config
  logic [7:0] vol_q, vol_d; // digital_volume, volume_code
  logic [7:0] sai_q, sai_d; // serial_port_config
  logic [7:0] rdata_q, rdata_d; // read answer, one cycle late

  // writes land whole; reserved bit 3 of converter_config is written too
  always_comb begin
    conv_d = conv_q;
    vol_d = vol_q;
    sai_d = sai_q;
    rdata_d = rdata_q;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CONV: conv_d = reg_wdata;
        ADDR_VOL: vol_d = reg_wdata;
        ADDR_SAI: sai_d = reg_wdata;
        default: ; // unmapped writes are dropped
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CONV: rdata_d = conv_q;
        ADDR_VOL: rdata_d = vol_q;
        ADDR_SAI: rdata_d = sai_q;
        default: rdata_d = 8'h00; // unmapped reads give zero
      endcase
    end
  end

  // reset values put the port in TDM with filter and low power on
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      conv_q <= RST_CONV;
      vol_q <= RST_VOL;
      sai_q <= RST_SAI;
      rdata_q <= 8'h00;
    end else begin
      conv_q <= conv_d;
      vol_q <= vol_d;
      sai_q <= sai_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  // converter settings leave as plain register bits
  assign low_power_enable = conv_q[CONV_LPM_BIT];
  assign sample_rate_range = conv_q[CONV_RATE_LSB +: 3];

  // -------------------------------------------------------------
  // configuration toward the receiver
  // -------------------------------------------------------------
  // these are quasi-static; the receiver resynchronises them itself
  assign link.sai_cfg = sai_q;
  assign link.word16 = word16_sel;
  assign link.auto_slot = auto_slot_sel;
  assign link.slot_field = slot_field;
  assign link.addr_slot = addr_slot_pin;

  // -------------------------------------------------------------
  // word crossing: toggle synchroniser plus holding register
  // -------------------------------------------------------------
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q; // s1 feeds s2 only
  logic new_word; // a word has crossed
  logic pend_q, pend_d; // held word waiting for the buffer
  logic [23:0] hold_q, hold_d; // word copied from the link
  logic push; // processed word enters the buffer
  logic pop; // consumer takes the head

  // the link word is stable for a whole frame after its toggle,
  // so it can be copied once the toggle has been seen here
  always_comb begin
    new_word = tgl_s2_q ^ tgl_s3_q;
    hold_d = new_word ? link.word : hold_q;
    // an arrival in the same cycle as the push keeps pending set
    pend_d = (pend_q && !push) || new_word;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      pend_q <= 1'b0;
      hold_q <= 24'h000000;
    end else begin
      tgl_s1_q <= link.tgl;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      pend_q <= pend_d;
      hold_q <= hold_d;
    end
  end

  // -------------------------------------------------------------
  // high-pass filter, gain, mute and polarity
  // -------------------------------------------------------------
  logic signed [25:0] xp_q, xp_d; // previous input
  logic signed [25:0] yp_q, yp_d; // previous filter output
  logic signed [25:0] xin, hp_y, filt;
  logic signed [23:0] s_in, gained;
  logic signed [41:0] prod;
  logic [4:0] gshift;
  logic [7:0] cur_q, cur_d; // volume code now applied
  logic signed [23:0] proc_d; // word as it enters the buffer
  logic muted;

  // a one-pole dc blocker; its state moves only with pushed words
  always_comb begin
    xin = 26'(signed'(hold_q));
    hp_y = xin - xp_q + yp_q - (yp_q >>> HPF_SHIFT);
    filt = conv_q[CONV_HPF_BIT] ? hp_y : xin;
    xp_d = push ? xin : xp_q;
    yp_d = push ? hp_y : yp_q;
    s_in = sat24(42'(filt));
    // each 16 codes is one octave, so split the code into shift and
    // fraction; an octave here is 6 dB, a hair under the ideal 6.02
    gshift = GAIN_SHIFT_BASE + {1'b0, cur_q[7:4]};
    prod = 42'(s_in) * 42'(signed'({1'b0, vol_mant(cur_q[3:0])}));
    gained = sat24(prod >>> gshift);
    muted = conv_q[CONV_MUTE_BIT] || (cur_q == VOL_MUTE_CODE);
    if (muted) proc_d = 24'sh000000;
    else if (sai_q[SAI_INV_BIT]) proc_d = sat24(-42'(gained));
    else proc_d = gained;
  end

  // soft ramp moves one 0.375 dB step per word, so clicks are
  // avoided at the cost of a slow approach at low sample rates
  always_comb begin
    cur_d = cur_q;
    if (conv_q[CONV_IMM_BIT]) cur_d = vol_q;
    else if (push && cur_q < vol_q) cur_d = cur_q + 8'h01;
    else if (push && cur_q > vol_q) cur_d = cur_q - 8'h01;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      xp_q <= 26'sh0000000;
      yp_q <= 26'sh0000000;
      cur_q <= RST_VOL;
    end else begin
      xp_q <= xp_d;
      yp_q <= yp_d;
      cur_q <= cur_d;
    end
  end

  // -------------------------------------------------------------
  // two-entry output buffer, head always in slot 0
  // -------------------------------------------------------------
  logic [23:0] b0_q, b0_d, b1_q, b1_d;
  logic v0_q, v0_d, v1_q, v1_d;

  // a full buffer holds the word in the crossing stage instead
  always_comb begin
    pop = v0_q && out_ready;
    push = pend_q && (!v1_q || pop);
    b0_d = b0_q;
    b1_d = b1_q;
    v0_d = v0_q;
    v1_d = v1_q;
    if (pop) begin
      b0_d = b1_q;
      v0_d = v1_q;
      v1_d = 1'b0;
    end
    if (push) begin
      if (!v0_d) begin
        b0_d = proc_d;
        v0_d = 1'b1;
      end else begin
        b1_d = proc_d;
        v1_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      b0_q <= 24'h000000;
      b1_q <= 24'h000000;
      v0_q <= 1'b0;
      v1_q <= 1'b0;
    end else begin
      b0_q <= b0_d;
      b1_q <= b1_d;
      v0_q <= v0_d;
      v1_q <= v1_d;
    end
  end

  assign out_data = b0_q;
  assign out_valid = v0_q;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  property p_sai_reset;
    @(posedge mclk) disable iff (rst) $fell(rst) |-> sai_q[FRAMING_MODE_SEL_BIT] == 1'b1;
  endproperty
  a_sai_reset: assert property (p_sai_reset) else $error("port not in TDM after reset");

  property p_hpf_reset;
    @(posedge mclk) disable iff (rst) $fell(rst) |-> conv_q[CONV_HPF_BIT] == 1'b1;
  endproperty
  a_hpf_reset: assert property (p_hpf_reset) else $error("filter off after reset");

  property p_lpm_reset;
    @(posedge mclk) disable iff (rst) $fell(rst) |-> low_power_enable == 1'b1;
  endproperty
  a_lpm_reset: assert property (p_lpm_reset) else $error("low power off after reset");

  property p_unity;
    @(posedge mclk) disable iff (rst)
      push && cur_q == RST_VOL && !conv_q[CONV_HPF_BIT] && !conv_q[CONV_MUTE_BIT]
      && !sai_q[SAI_INV_BIT] |=> (v1_q ? b1_q : b0_q) == $past(hold_q);
  endproperty
  a_unity: assert property (p_unity) else $error("unity code changed the word");

  property p_invert;
    @(posedge mclk) disable iff (rst)
      push && cur_q == RST_VOL && !conv_q[CONV_HPF_BIT] && !conv_q[CONV_MUTE_BIT]
      && sai_q[SAI_INV_BIT] && hold_q != 24'h800000
      |=> (v1_q ? b1_q : b0_q) == 24'(-$past(hold_q));
  endproperty
  a_invert: assert property (p_invert) else $error("polarity not inverted");

  property p_mute_code;
    @(posedge mclk) disable iff (rst)
      push && cur_q == VOL_MUTE_CODE |=> (v1_q ? b1_q : b0_q) == 24'h000000;
  endproperty
  a_mute_code: assert property (p_mute_code) else $error("mute code passed audio");

  property p_mute_bit;
    @(posedge mclk) disable iff (rst)
      push && conv_q[CONV_MUTE_BIT] |=> (v1_q ? b1_q : b0_q) == 24'h000000;
  endproperty
  a_mute_bit: assert property (p_mute_bit) else $error("mute bit passed audio");

  property p_hard_vol;
    @(posedge mclk) disable iff (rst)
      conv_q[CONV_IMM_BIT] && cur_q != vol_q |=> cur_q == $past(vol_q);
  endproperty
  a_hard_vol: assert property (p_hard_vol) else $error("hard volume not immediate");

  property p_soft_step;
    @(posedge mclk) disable iff (rst)
      !conv_q[CONV_IMM_BIT] && !push ##1 !conv_q[CONV_IMM_BIT] |-> $stable(cur_q);
  endproperty
  a_soft_step: assert property (p_soft_step) else $error("ramp moved without a word");
endmodule : aipv_top

// >>> dv/aipv_host_model.sv
// behavioural host driving the serial audio bus
`timescale 1ns/1ns
module aipv_host_model (
  output logic bclk,
  output logic frame_sync_pin,
  output logic serial_data_pin
);
  // the bit clock rests low between ticks
  initial begin
    bclk = 1'b0;
    frame_sync_pin = 1'b0;
    serial_data_pin = 1'b0;
  end
  // one 6 ns bit clock; sync and data move on the edge that is not sampled
  task automatic tick(input logic edg, input logic s, input logic d);
    bclk = edg;
    frame_sync_pin = s;
    serial_data_pin = d;
    #3 bclk = ~edg;
    #3 bclk = 1'b0;
  endtask : tick
  // idle clocks: sync held, released data toggles so no stale level survives
  task automatic idle(input int n);
    repeat (n) tick(1'b0, frame_sync_pin, ~serial_data_pin);
  endtask : idle
  // one frame of 160 bit clocks, nb bits of w msb first from position off
  task automatic frame(input logic tdm, input logic sty, input logic edg,
    input int off, input int nb, input logic [23:0] w);
    logic s;
    logic d;
    repeat (4) tick(edg, tdm ? 1'b0 : ~sty, ~serial_data_pin);
    for (int p = 0; p < 160; p++) begin
      s = (tdm && !sty) ? (p == 0) : ((p < 80) ? (tdm | sty) : ~(tdm | sty));
      d = (p >= off && p < off + nb) ? w[23 - (p - off)] : p[0];
      tick(edg, s, d);
    end
    repeat (2) tick(edg, s, ~d);
  endtask : frame
endmodule : aipv_host_model

// >>> dv/testbench.sv
// self-checking bench for the audio input port core
`timescale 1ns/1ns
module testbench;
  import aipv_pkg::*;
  logic mclk, rst, bclk, fs, sd, word16_sel, auto_slot_sel, reg_wr, reg_rd;
  logic out_valid, out_ready, low_power_enable;
  logic [3:0] slot_field;
  logic [2:0] sample_rate_range;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [23:0] out_data;
  int bad_count, compares;
  aipv_host_model aipv_host_model_i (.bclk(bclk), .frame_sync_pin(fs), .serial_data_pin(sd));
  aipv_top aipv_top_i (.mclk(mclk), .rst(rst), .bclk(bclk), .frame_sync_pin(fs),
    .serial_data_pin(sd), .addr_slot_pin(2'h1), .word16_sel(word16_sel),
    .auto_slot_sel(auto_slot_sel), .slot_field(slot_field), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
    .low_power_enable(low_power_enable), .sample_rate_range(sample_rate_range));
  // ---------------------------------------------------------------
  // clock, compares and bus tasks
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_smp(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_smp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr
  // read data is registered, so sample a full cycle after the strobe drops
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask : rd
  // take one sample from the output stream, bounded wait
  task automatic pop(output logic [23:0] v);
    int n;
    n = 0;
    @(negedge mclk);
    while (out_valid !== 1'b1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 400) chk_reg({7'h0, out_valid}, 8'h01);
    v = out_data;
    out_ready = 1'b1;
    @(negedge mclk);
    out_ready = 1'b0;
  endtask : pop
  // program all three registers, clock the link so the setting lands, flush strays
  task automatic cfg(input logic [7:0] c, input logic [7:0] v, input logic [7:0] s);
    wr(ADDR_CONV, c);
    wr(ADDR_VOL, v);
    wr(ADDR_SAI, s);
    aipv_host_model_i.idle(8);
    @(negedge mclk);
    out_ready = 1'b1;
    repeat (12) @(negedge mclk);
    out_ready = 1'b0;
  endtask : cfg
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] v;
    rd(ADDR_CONV, v);
    chk_reg(v, 8'h32);
    rd(ADDR_VOL, v);
    chk_reg(v, 8'h40);
    rd(ADDR_SAI, v);
    chk_reg(v, 8'h11);
    chk_reg({7'h0, low_power_enable}, 8'h01);
    for (int r = 0; r < 8; r++) begin
      wr(ADDR_CONV, {5'h04, 3'(r)});
      rd(ADDR_CONV, v);
      chk_reg(v, {5'h04, 3'(r)});
      chk_reg({5'h0, sample_rate_range}, 8'(r));
    end
    chk_reg({7'h0, low_power_enable}, 8'h00);
    wr(8'h07, 8'haa);
    rd(8'h07, v);
    chk_reg(v, 8'h00);
    $display("done: registers");
  endtask : t_regs
  // every stereo sync level, data delay and sample edge
  task automatic t_stereo;
    logic [23:0] w, v;
    for (int i = 0; i < 8; i++) begin
      cfg(8'h80, 8'h40, {1'b0, i[2], 3'h2, i[0], i[1], 1'b0});
      w = 24'h9a3c0f ^ 24'(i * 'h10501);
      aipv_host_model_i.frame(1'b0, i[0], i[2], !i[1], 24, w);
      pop(v);
      chk_smp(v, w);
    end
    $display("done: stereo");
  endtask : t_stereo
  // each slot width with slot 1, last case takes its slot from the pin
  task automatic t_tdm;
    int sb[5];
    logic [23:0] w, v;
    sb = '{16, 24, 32, 48, 64};
    for (int c = 0; c < 5; c++) begin
      word16_sel = (c == 0);
      auto_slot_sel = (c == 4);
      slot_field = (c == 4) ? 4'h0 : 4'h1;
      cfg(8'h80, 8'h40, {1'b0, c[2], 3'(c), c[0], c[1], 1'b1});
      w = 24'h3c5a96 ^ 24'(c << 12);
      aipv_host_model_i.frame(1'b1, c[0], c[2], sb[c] + !c[1], (c == 0) ? 16 : 24, w);
      pop(v);
      chk_smp(v, (c == 0) ? {w[23:8], 8'h00} : w);
    end
    word16_sel = 1'b0;
    $display("done: tdm");
  endtask : t_tdm
  // gain steps, saturation, mute, restore, invert, soft ramp and deepest step
  task automatic t_gain;
    logic [7:0] cv[7] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'hc0, 8'h80, 8'h80};
    logic [7:0] vl[7] = '{8'h30, 8'h50, 8'h00, 8'hff, 8'h40, 8'h40, 8'h40};
    logic [23:0] ex[7] = '{24'h2468ac, 24'h091a2b, 24'h7fffff, 24'h0, 24'h0,
      24'h123456, 24'hedcbaa};
    logic [23:0] v;
    for (int i = 0; i < 7; i++) begin
      cfg(cv[i], vl[i], (i == 6) ? 8'h92 : 8'h12);
      aipv_host_model_i.frame(1'b0, 1'b0, 1'b0, 0, 24, 24'h123456);
      pop(v);
      chk_smp(v, ex[i]);
    end
    cfg(8'h00, 8'h30, 8'h12);
    repeat (2) aipv_host_model_i.frame(1'b0, 1'b0, 1'b0, 0, 24, 24'h123456);
    pop(v);
    pop(v);
    chk_reg({7'h0, v > 24'h123456 && v < 24'h2468ac}, 8'h01);
    cfg(8'h80, 8'hfe, 8'h12);
    aipv_host_model_i.frame(1'b0, 1'b0, 1'b0, 0, 24, 24'h7fffff);
    pop(v);
    chk_reg({7'h0, v > 24'h0 && v < 24'h001000}, 8'h01);
    $display("done: gain");
  endtask : t_gain
  // three words while stalled: two buffered plus one crossing, none lost
  task automatic t_buf;
    logic [23:0] v;
    cfg(8'h80, 8'h40, 8'h12);
    for (int i = 1; i < 4; i++) aipv_host_model_i.frame(1'b0, 1'b0, 1'b0, 0, 24, 24'(i * 'h111111));
    repeat (20) @(negedge mclk);
    chk_reg({7'h0, out_valid}, 8'h01);
    for (int i = 1; i < 4; i++) begin
      pop(v);
      chk_smp(v, 24'(i * 'h111111));
    end
    $display("done: buffer");
  endtask : t_buf
  // ---------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ---------------------------------------------------------------
  task automatic results;
    $display("Checks %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  initial begin
    #400000;
    bad_count++;
    results();
  end
  // reset spans idle link clocks so both domains clear; release with link quiet
  initial begin
    {rst, word16_sel, auto_slot_sel, reg_wr, reg_rd, out_ready} = 6'h20;
    slot_field = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    aipv_host_model_i.idle(4);
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    t_regs();
    t_stereo();
    t_tdm();
    t_gain();
    t_buf();
    results();
  end
endmodule : testbench
